// *** design/fifo_decimator.sv ***
/*
  Decimator for samples entering the FIFO: passes one in 2^exp.
  Assumes sample strobes are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module fifo_decimator
  import gyro_cfg_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  exp_i,
  input  wire logic        sample_i,
  output logic             pass_o
);

  logic [6:0] count_ff;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << exp_i) - 8'h01);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_ff <= 7'h00;
      pass_o   <= 1'b0;
    end else begin
      pass_o <= 1'b0;
      if (sample_i) begin
        if (count_ff >= limit) begin
          count_ff <= 7'h00;
          pass_o   <= 1'b1;
        end else begin
          count_ff <= count_ff + 7'h01;
        end
      end
    end
  end

endmodule : fifo_decimator

// *** design/gyro_range_fifo_config_regs.sv ***
/*
  Configuration register group of a triaxial rate sensor: range, FIFO
  decimation and source, watermark, FIFO format, interrupt engine enables.
  Assumes a byte-wide register port decoded by the host serial interface,
  and a FIFO frame engine that reports frame pushes and pops.
*/
`timescale 1ns/1ps
module gyro_range_fifo_config_regs
  import gyro_cfg_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  // Register port
  input  wire logic [6:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [7:0]              reg_rdata_o,
  output logic                    reg_rvalid_o,
  // Sample path
  input  wire logic               raw_sample_i,
  input  wire logic               filt_sample_i,
  input  wire logic               sample_ready_set_i,
  input  wire logic               sample_read_i,
  // FIFO engine
  input  wire logic [FILL_W-1:0]  frame_bytes_i,
  input  wire logic               frame_push_i,
  input  wire logic               frame_pop_i,
  input  wire logic               fifo_flush_i,
  input  wire logic [FILL_W-1:0]  fifo_capacity_i,
  // Pins used for tagging
  input  wire logic               irq_pin_a_i,
  input  wire logic               irq_pin_b_i,
  // Controls toward FIFO engine
  output logic                    fifo_enable_o,
  output logic                    fifo_sample_push_o,
  output logic                    fifo_source_filtered_o,
  output logic                    header_enable_o,
  output logic                    pin_a_tag_o,
  output logic                    pin_b_tag_o,
  output logic                    time_frame_enable_o,
  output logic                    fifo_full_o,
  output logic [FILL_W-1:0]       fill_bytes_o,
  // Range outputs
  output logic [11:0]             full_scale_dps_o,
  output logic [11:0]             scale_x10_o,
  output logic                    range_legal_o,
  // Interrupt status
  output logic                    wm_status_o,
  output logic                    full_status_o,
  output logic                    ready_status_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]        range_ff;
  logic [7:0]        decim_ff;
  logic [7:0]        setup_lo_ff;
  logic [7:0]        setup_hi_ff;
  logic [7:0]        irq_en_ff;
  logic [FILL_W-1:0] fill_ff;
  logic              ready_ff;
  wr_state_t         wr_state_ff;

  logic              capture_en;
  logic              sel_sample;
  logic              dec_pass;
  logic              full_now;
  logic [FILL_W+1:0] wm_bytes;
  logic [7:0]        nxt_rdata;
  logic              comb_legal;
  logic [11:0]       comb_fs;
  logic [11:0]       comb_scale;

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      range_ff    <= RATE_RANGE_RST;
      decim_ff    <= FIFO_DECIMATION_RST;
      setup_lo_ff <= FIFO_SETUP_LO_RST;
      setup_hi_ff <= FIFO_SETUP_HI_RST;
      irq_en_ff   <= IRQ_ENGINE_ENABLE_RST;
    end else if (reg_wr_i) begin
      // Reserved bits are kept at zero regardless of host writes
      case (reg_addr_i)
        RATE_RANGE_SELECT_ADDR: range_ff    <= reg_wdata_i & RATE_RANGE_MASK;
        FIFO_DECIMATION_ADDR:   decim_ff    <= reg_wdata_i & FIFO_DECIMATION_MASK;
        FIFO_SETUP_LO_ADDR:     setup_lo_ff <= reg_wdata_i;
        FIFO_SETUP_HI_ADDR:     setup_hi_ff <= reg_wdata_i & FIFO_SETUP_HI_MASK;
        IRQ_ENGINE_ENABLE_ADDR: irq_en_ff   <= reg_wdata_i & IRQ_ENGINE_ENABLE_MASK;
        default: begin
        end
      endcase
    end
  end

  // Tracks write completion; only informational for the read path
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_state_ff <= WR_IDLE;
    end else begin
      case (wr_state_ff)
        WR_IDLE: wr_state_ff <= reg_wr_i ? WR_DONE : WR_IDLE;
        WR_DONE: wr_state_ff <= reg_wr_i ? WR_DONE : WR_IDLE;
        default: wr_state_ff <= WR_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  always_comb begin
    case (reg_addr_i)
      RATE_RANGE_SELECT_ADDR: nxt_rdata = range_ff;
      FIFO_DECIMATION_ADDR:   nxt_rdata = decim_ff;
      FIFO_SETUP_LO_ADDR:     nxt_rdata = setup_lo_ff;
      FIFO_SETUP_HI_ADDR:     nxt_rdata = setup_hi_ff;
      IRQ_ENGINE_ENABLE_ADDR: nxt_rdata = irq_en_ff;
      default:                nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= nxt_rdata;
      end
    end
  end

  // ************************************************************
  // Sample ready flag
  // ************************************************************
  // Range writes do not touch this flag; a sample read clears it,
  // and a new sample in the same cycle wins over the clear.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_ff <= 1'b0;
    end else if (sample_ready_set_i) begin
      ready_ff <= 1'b1;
    end else if (sample_read_i) begin
      ready_ff <= 1'b0;
    end
  end

  // ************************************************************
  // FIFO input path
  // ************************************************************
  assign capture_en = setup_hi_ff[SETUP_CAPTURE_BIT];
  assign sel_sample = decim_ff[DECIM_FILT_BIT] ? filt_sample_i
                                               : raw_sample_i;
  assign full_now   = (fill_ff >= fifo_capacity_i);

  fifo_decimator u_decim (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .exp_i     (decim_ff[DECIM_EXP_LSB +: DECIM_EXP_W]),
    .sample_i  (sel_sample & capture_en),
    .pass_o    (dec_pass)
  );

  // Halt-when-full drops pushes; otherwise the engine overwrites oldest
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_sample_push_o <= 1'b0;
    end else begin
      fifo_sample_push_o <= dec_pass & capture_en &
                            ~(setup_hi_ff[SETUP_HALT_BIT] & full_now);
    end
  end

  // ************************************************************
  // Fill-byte count
  // ************************************************************
  // Only whole frames, a flush or disabling capture move the count; partial reads do not
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fill_ff <= '0;
    end else if (fifo_flush_i || !capture_en) begin
      fill_ff <= '0;
    end else begin
      case ({frame_push_i, frame_pop_i})
        2'b10:   fill_ff <= fill_ff + frame_bytes_i;
        2'b01:   fill_ff <= (fill_ff > frame_bytes_i) ? fill_ff - frame_bytes_i : '0;
        default: fill_ff <= fill_ff;
      endcase
    end
  end

  assign wm_bytes = {2'b00, FILL_W'({setup_lo_ff, 2'b00})};

  // ************************************************************
  // Outputs toward FIFO engine and status
  // ************************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_enable_o          <= 1'b0;
      fifo_source_filtered_o <= 1'b0;
      header_enable_o        <= 1'b0;
      pin_a_tag_o            <= 1'b0;
      pin_b_tag_o            <= 1'b0;
      time_frame_enable_o    <= 1'b0;
      fifo_full_o            <= 1'b0;
      fill_bytes_o           <= '0;
    end else begin
      fifo_enable_o          <= capture_en;
      fifo_source_filtered_o <= decim_ff[DECIM_FILT_BIT];
      header_enable_o        <= capture_en & setup_hi_ff[SETUP_HEADER_BIT];
      pin_a_tag_o            <= capture_en & setup_hi_ff[SETUP_PIN_A_BIT] & irq_pin_a_i;
      pin_b_tag_o            <= capture_en & setup_hi_ff[SETUP_PIN_B_BIT] & irq_pin_b_i;
      time_frame_enable_o    <= capture_en & setup_hi_ff[SETUP_TIME_BIT];
      fifo_full_o            <= full_now;
      fill_bytes_o           <= fill_ff;
    end
  end

  // Status bits follow their condition level while their own interrupt engine enable bit is set
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wm_status_o    <= 1'b0;
      full_status_o  <= 1'b0;
      ready_status_o <= 1'b0;
    end else begin
      wm_status_o    <= irq_en_ff[IRQ_WM_BIT] &
                        ({2'b00, fill_ff} > wm_bytes);
      full_status_o  <= irq_en_ff[IRQ_FULL_BIT] & full_now;
      ready_status_o <= irq_en_ff[IRQ_READY_BIT] & ready_ff;
    end
  end

  // ************************************************************
  // Range decode
  // ************************************************************
  range_scale_decode u_range (
    .range_code_i     (range_ff[2:0]),
    .range_legal_o    (comb_legal),
    .full_scale_dps_o (comb_fs),
    .scale_x10_o      (comb_scale)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      range_legal_o    <= 1'b1;
      full_scale_dps_o <= FULL_SCALE_WIDEST;
      scale_x10_o      <= SCALE_X10_WIDEST;
    end else begin
      range_legal_o    <= comb_legal;
      full_scale_dps_o <= comb_fs;
      scale_x10_o      <= comb_scale;
    end
  end

endmodule : gyro_range_fifo_config_regs

// *** design/range_scale_decode.sv ***
/*
  Range code decoder: full scale and sensitivity for the selected range.
  Assumes the code is a registered field of the configuration block.
*/
`timescale 1ns/1ps
module range_scale_decode
  import gyro_cfg_pkg::*;
(
  input  wire logic [2:0]  range_code_i,
  output logic             range_legal_o,
  output logic [11:0]      full_scale_dps_o,
  output logic [11:0]      scale_x10_o
);

  // Each narrower range halves full scale and doubles sensitivity
  always_comb begin
    range_legal_o    = (range_code_i <= RANGE_125);
    full_scale_dps_o = FULL_SCALE_WIDEST >> range_code_i;
    scale_x10_o      = SCALE_X10_WIDEST << range_code_i;
    if (!range_legal_o) begin
      full_scale_dps_o = 12'h000;
      scale_x10_o      = 12'h000;
    end
  end

endmodule : range_scale_decode

// *** shared/gyro_cfg_pkg.sv ***
/*
  Package for the rate-sensor configuration register group: byte addresses,
  field positions, reset values and code tables.
  Assumes byte-wide register access from the host serial interface logic.
*/
package gyro_cfg_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [6:0] RATE_RANGE_SELECT_ADDR  = 7'h43;
  localparam logic [6:0] FIFO_DECIMATION_ADDR    = 7'h45;
  localparam logic [6:0] FIFO_SETUP_LO_ADDR      = 7'h46;
  localparam logic [6:0] FIFO_SETUP_HI_ADDR      = 7'h47;
  localparam logic [6:0] IRQ_ENGINE_ENABLE_ADDR  = 7'h51;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RATE_RANGE_RST          = 8'h00;
  localparam logic [7:0] FIFO_DECIMATION_RST     = 8'h00;
  localparam logic [7:0] FIFO_SETUP_LO_RST       = 8'h80;
  localparam logic [7:0] FIFO_SETUP_HI_RST       = 8'h10;
  localparam logic [7:0] IRQ_ENGINE_ENABLE_RST   = 8'h00;

  // ************************************************************
  // Writable field masks
  // ************************************************************
  localparam logic [7:0] RATE_RANGE_MASK         = 8'h07;
  localparam logic [7:0] FIFO_DECIMATION_MASK    = 8'h0F;
  localparam logic [7:0] FIFO_SETUP_HI_MASK      = 8'h9F;
  localparam logic [7:0] IRQ_ENGINE_ENABLE_MASK  = 8'h70;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DECIM_EXP_LSB      = 0;
  localparam int DECIM_EXP_W        = 3;
  localparam int DECIM_FILT_BIT     = 3;
  localparam int SETUP_CAPTURE_BIT  = 7;
  localparam int SETUP_HEADER_BIT   = 4;
  localparam int SETUP_PIN_A_BIT    = 3;
  localparam int SETUP_PIN_B_BIT    = 2;
  localparam int SETUP_TIME_BIT     = 1;
  localparam int SETUP_HALT_BIT     = 0;
  localparam int IRQ_WM_BIT         = 6;
  localparam int IRQ_FULL_BIT       = 5;
  localparam int IRQ_READY_BIT      = 4;

  // ************************************************************
  // Range codes and scaling (counts per dps, times ten)
  // ************************************************************
  localparam logic [2:0] RANGE_2000 = 3'h0;
  localparam logic [2:0] RANGE_1000 = 3'h1;
  localparam logic [2:0] RANGE_500  = 3'h2;
  localparam logic [2:0] RANGE_250  = 3'h3;
  localparam logic [2:0] RANGE_125  = 3'h4;
  localparam logic [11:0] SCALE_X10_WIDEST = 12'h0A4;
  localparam logic [11:0] FULL_SCALE_WIDEST = 12'h7D0;

  // Watermark threshold unit in bytes, as a shift
  localparam int WM_UNIT_SHIFT = 2;
  localparam int FILL_W        = 11;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_DONE = 2'b01
  } wr_state_t;

endpackage : gyro_cfg_pkg

// *** testbench/gyro_cfg_asserts.sv ***
/*
  Checker for the rate-sensor configuration registers, bound to the top.
  Assumes one clock domain and the registered output timing of the block.
*/
`timescale 1ns/1ps
module gyro_cfg_checker
  import gyro_cfg_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [6:0]        reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic              reg_rvalid_o,
  input wire logic              raw_sample_i,
  input wire logic              filt_sample_i,
  input wire logic              sample_read_i,
  input wire logic              frame_push_i,
  input wire logic              frame_pop_i,
  input wire logic              fifo_flush_i,
  input wire logic              irq_pin_a_i,
  input wire logic              fifo_enable_o,
  input wire logic              fifo_sample_push_o,
  input wire logic              fifo_source_filtered_o,
  input wire logic              header_enable_o,
  input wire logic              pin_a_tag_o,
  input wire logic              time_frame_enable_o,
  input wire logic [FILL_W-1:0] fill_bytes_o,
  input wire logic [11:0]       full_scale_dps_o,
  input wire logic [11:0]       scale_x10_o,
  input wire logic              range_legal_o,
  input wire logic              wm_status_o,
  input wire logic              ready_status_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ************************************************************
  // Range decode
  // ************************************************************
  a_scale_product: assert property (range_legal_o |->
    32'(full_scale_dps_o) * 32'(scale_x10_o) == 32'h0005_0140) else $error("scale product");
  a_scale_set: assert property (range_legal_o |->
    scale_x10_o inside {12'h0A4, 12'h148, 12'h290, 12'h520, 12'hA40}) else $error("bad scale");
  a_ready_hold: assert property (ready_status_o && reg_wr_i && !sample_read_i
    && reg_addr_i == RATE_RANGE_SELECT_ADDR && !$past(sample_read_i) |=> ready_status_o)
    else $error("range write cleared ready");

  // ************************************************************
  // FIFO controls
  // ************************************************************
  a_push_source: assert property (fifo_sample_push_o |->
    ($past(fifo_source_filtered_o) ? $past(filt_sample_i, 2) : $past(raw_sample_i, 2)))
    else $error("push without selected sample");
  a_push_capture: assert property (fifo_sample_push_o |->
    fifo_enable_o || $past(fifo_enable_o)) else $error("push while disabled");
  a_fmt_capture: assert property (header_enable_o || time_frame_enable_o |->
    fifo_enable_o || $past(fifo_enable_o)) else $error("format bits while disabled");
  a_tag_pin: assert property (pin_a_tag_o |-> $past(irq_pin_a_i))
    else $error("tag without pin");
  a_wm_fill: assert property (wm_status_o |->
    fill_bytes_o != '0 || $past(fill_bytes_o) != '0) else $error("watermark on empty");
  a_fill_cause: assert property ($changed(fill_bytes_o) |->
    $past(frame_push_i) || $past(frame_pop_i) || $past(fifo_flush_i)
    || $past(frame_push_i, 2) || $past(frame_pop_i, 2) || $past(fifo_flush_i, 2)
    || !fifo_enable_o || !$past(fifo_enable_o)) else $error("fill changed alone");
  a_flush_empty: assert property (fifo_flush_i && !frame_push_i |->
    ##[1:2] fill_bytes_o == '0) else $error("flush left fill");
  a_read_answer: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer timing");

  c_wm: cover property (wm_status_o);
  c_push: cover property (fifo_sample_push_o);
  c_ready_wr: cover property (ready_status_o && reg_wr_i);
endmodule : gyro_cfg_checker

bind gyro_range_fifo_config_regs gyro_cfg_checker u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
  .raw_sample_i(raw_sample_i), .filt_sample_i(filt_sample_i),
  .sample_read_i(sample_read_i), .frame_push_i(frame_push_i), .frame_pop_i(frame_pop_i),
  .fifo_flush_i(fifo_flush_i), .irq_pin_a_i(irq_pin_a_i), .fifo_enable_o(fifo_enable_o),
  .fifo_sample_push_o(fifo_sample_push_o), .header_enable_o(header_enable_o),
  .fifo_source_filtered_o(fifo_source_filtered_o),
  .pin_a_tag_o(pin_a_tag_o), .time_frame_enable_o(time_frame_enable_o),
  .fill_bytes_o(fill_bytes_o), .full_scale_dps_o(full_scale_dps_o),
  .scale_x10_o(scale_x10_o), .range_legal_o(range_legal_o),
  .wm_status_o(wm_status_o), .ready_status_o(ready_status_o));

// *** testbench/gyro_range_fifo_config_regs_test.sv ***
/*
  Self-checking bench for the configuration registers, driven by the host model.
  Assumes the checker is bound separately and the FIFO engine is the bench.
*/
`timescale 1ns/1ps
module gyro_range_fifo_config_regs_test;
  import gyro_cfg_pkg::*;
  localparam int RAW = 0, FLT = 1, RDY = 2, SRD = 3, PSH = 4, POP = 5, FLS = 6;
  localparam logic [6:0] RA [6] = '{RATE_RANGE_SELECT_ADDR, FIFO_DECIMATION_ADDR,
    FIFO_SETUP_LO_ADDR, FIFO_SETUP_HI_ADDR, IRQ_ENGINE_ENABLE_ADDR, 7'h50};
  localparam logic [7:0] RV [6] = '{RATE_RANGE_RST, FIFO_DECIMATION_RST,
    FIFO_SETUP_LO_RST, FIFO_SETUP_HI_RST, IRQ_ENGINE_ENABLE_RST, 8'h00};
  localparam logic [7:0] RM [6] = '{RATE_RANGE_MASK, FIFO_DECIMATION_MASK, 8'hFF,
    FIFO_SETUP_HI_MASK, IRQ_ENGINE_ENABLE_MASK, 8'h00};

  logic              ref_clk_i;
  logic              sys_rst_i = 1'b1;
  logic [6:0]        strb = 7'h00;
  logic [FILL_W-1:0] frame_bytes = '0, fill_bytes_o;
  logic              irq_pin_a_i = 1'b0, irq_pin_b_i = 1'b0;
  logic [6:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i, reg_rdata_o;
  logic              reg_wr_i, reg_rd_i, reg_rvalid_o, range_legal_o;
  logic              fifo_enable_o, fifo_sample_push_o, fifo_source_filtered_o;
  logic              header_enable_o, pin_a_tag_o, pin_b_tag_o, time_frame_enable_o;
  logic              fifo_full_o, wm_status_o, full_status_o, ready_status_o;
  logic [11:0]       full_scale_dps_o, scale_x10_o;
  logic [24:0]       exp_rng;
  int                mismatches = 0, check_count = 0, pushes = 0, cycles = 0;

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  reg_host_model u_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

  gyro_range_fifo_config_regs u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .raw_sample_i(strb[RAW]), .filt_sample_i(strb[FLT]), .sample_ready_set_i(strb[RDY]),
    .sample_read_i(strb[SRD]), .frame_bytes_i(frame_bytes), .frame_push_i(strb[PSH]),
    .frame_pop_i(strb[POP]), .fifo_flush_i(strb[FLS]), .fifo_capacity_i(11'h00C),
    .irq_pin_a_i(irq_pin_a_i), .irq_pin_b_i(irq_pin_b_i), .fifo_enable_o(fifo_enable_o),
    .fifo_sample_push_o(fifo_sample_push_o), .fifo_source_filtered_o(fifo_source_filtered_o),
    .header_enable_o(header_enable_o), .pin_a_tag_o(pin_a_tag_o), .pin_b_tag_o(pin_b_tag_o),
    .time_frame_enable_o(time_frame_enable_o), .fifo_full_o(fifo_full_o),
    .fill_bytes_o(fill_bytes_o), .full_scale_dps_o(full_scale_dps_o),
    .scale_x10_o(scale_x10_o), .range_legal_o(range_legal_o), .wm_status_o(wm_status_o),
    .full_status_o(full_status_o), .ready_status_o(ready_status_o));

  // ************************************************************
  // Helpers
  // ************************************************************
  always @(posedge ref_clk_i) if (fifo_sample_push_o === 1'b1) pushes++;

  // Ceiling is about twenty times the expected run
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.read(a, d);
    check(32'(d), 32'(e));
  endtask : rd_chk

  // Status outputs trail their inputs by up to two registers
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : settle

  task automatic pulse(input int b);
    @(posedge ref_clk_i);
    strb[b] <= 1'b1;
    @(posedge ref_clk_i);
    strb[b] <= 1'b0;
  endtask : pulse

  task automatic frame(input int b, input logic [FILL_W-1:0] n);
    @(posedge ref_clk_i);
    frame_bytes <= n;
    strb[b]     <= 1'b1;
    @(posedge ref_clk_i);
    strb[b]     <= 1'b0;
    settle();
  endtask : frame

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(RA[i], RV[i]);
    for (int i = 0; i < 6; i++) begin
      u_host.write(RA[i], 8'hFF);
      rd_chk(RA[i], RM[i]);
    end
    $display("Test registers done");
    for (int k = 0; k < 8; k++) begin
      u_host.write(RATE_RANGE_SELECT_ADDR, 8'(k));
      settle();
      exp_rng = (k < 5) ? {1'b1, 12'h7D0 >> k, 12'h0A4 << k} : 25'h0000000;
      check(32'({range_legal_o, full_scale_dps_o, scale_x10_o}), 32'(exp_rng));
      rd_chk(RATE_RANGE_SELECT_ADDR, 8'(k));
    end
    u_host.write(IRQ_ENGINE_ENABLE_ADDR, 8'h10);
    pulse(RDY);
    u_host.write(RATE_RANGE_SELECT_ADDR, 8'h03);
    settle();
    check(32'(ready_status_o), 32'h1);
    pulse(SRD);
    settle();
    check(32'(ready_status_o), 32'h0);
    $display("Test range done");
    u_host.write(FIFO_SETUP_HI_ADDR, 8'h80);
    u_host.write(FIFO_DECIMATION_ADDR, 8'h02);
    pushes = 0;
    for (int i = 0; i < 8; i++) begin
      pulse(RAW);
      pulse(FLT);
    end
    settle();
    check(32'(pushes), 32'h2);
    u_host.write(FIFO_DECIMATION_ADDR, 8'h09);
    pushes = 0;
    for (int i = 0; i < 4; i++) begin
      pulse(FLT);
      pulse(RAW);
    end
    settle();
    check(32'({pushes[3:0], fifo_source_filtered_o}), 32'h5);
    $display("Test decimation done");
    u_host.write(FIFO_SETUP_LO_ADDR, 8'h02);
    u_host.write(IRQ_ENGINE_ENABLE_ADDR, 8'h70);
    frame(PSH, 11'h008);
    check(32'({fill_bytes_o, wm_status_o}), 32'({11'h008, 1'b0}));
    frame(PSH, 11'h004);
    check(32'({fill_bytes_o, wm_status_o, full_status_o}), 32'({11'h00C, 2'b11}));
    u_host.write(IRQ_ENGINE_ENABLE_ADDR, 8'h40);
    settle();
    check(32'({wm_status_o, full_status_o, fifo_full_o}), 32'h5);
    u_host.write(FIFO_SETUP_HI_ADDR, 8'h81);
    u_host.write(FIFO_DECIMATION_ADDR, 8'h00);
    pushes = 0;
    pulse(RAW);
    settle();
    check(32'(pushes), 32'h0);
    u_host.write(FIFO_SETUP_HI_ADDR, 8'h80);
    pulse(RAW);
    settle();
    check(32'(pushes), 32'h1);
    frame(POP, 11'h00C);
    check(32'({fill_bytes_o, wm_status_o, fifo_full_o}), 32'h0);
    frame(PSH, 11'h004);
    pulse(FLS);
    settle();
    check(32'(fill_bytes_o), 32'h0);
    $display("Test fill done");
    @(posedge ref_clk_i);
    irq_pin_a_i <= 1'b1;
    irq_pin_b_i <= 1'b1;
    u_host.write(FIFO_SETUP_HI_ADDR, 8'h9E);
    settle();
    check(32'({fifo_enable_o, header_enable_o, pin_a_tag_o, pin_b_tag_o,
               time_frame_enable_o}), 32'h1F);
    @(posedge ref_clk_i);
    irq_pin_a_i <= 1'b0;
    settle();
    check(32'({pin_a_tag_o, pin_b_tag_o}), 32'h1);
    u_host.write(FIFO_SETUP_HI_ADDR, 8'h1E);
    frame(PSH, 11'h004);
    check(32'({fifo_enable_o, header_enable_o, pin_b_tag_o, time_frame_enable_o,
               fill_bytes_o}), 32'h0);
    pushes = 0;
    pulse(RAW);
    settle();
    check(32'(pushes), 32'h0);
    $display("Test format done");
    print_verdict();
  end
endmodule : gyro_range_fifo_config_regs_test

// *** testbench/reg_host_model.sv ***
/*
  Host model for the configuration register port: byte writes and reads.
  Assumes the caller runs in the core clock domain and waits for each task.
*/
`timescale 1ns/1ps
module reg_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic [6:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o  = 7'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // Callers keep reserved bits zero except in refusal tests
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    // Stale data would hide a strobe-free capture
    reg_wdata_o <= ~d;
  endtask : write

  task automatic read(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    #1;
    d = reg_rvalid_i ? reg_rdata_i : 'x;
  endtask : read
endmodule : reg_host_model
